// ### core/eldet_consts.svh
// constants for the external line edge detector: offsets, field positions, reset values
`ifndef ELDET_CONSTS_SVH
`define ELDET_CONSTS_SVH
`define ELDET_NUM_LINES 22
`define ELDET_ADDR_W 5
`define ELDET_OFF_INT_MASK 5'h00
`define ELDET_OFF_EVT_MASK 5'h04
`define ELDET_OFF_RISE_SEL 5'h08
`define ELDET_OFF_FALL_SEL 5'h0c
`define ELDET_OFF_SOFT_TRIG 5'h10
`define ELDET_OFF_PENDING 5'h14
`define ELDET_GPIO_LINES 16
`define ELDET_LINE_LVD 16
`define ELDET_LINE_ALARM 17
`define ELDET_LINE_USB 18
`define ELDET_LINE_ENET 19
`define ELDET_LINE_I2C 20
`define ELDET_LINE_UART 21
`define ELDET_RESET_WORD 32'h0000_0000
`endif

// ### core/eldet_pkg.sv
// types for the external line edge detector
package eldet_pkg;
  typedef enum logic [5:0] {
    ELDET_REG_INT_MASK = 6'h01,
    ELDET_REG_EVT_MASK = 6'h02,
    ELDET_REG_RISE_SEL = 6'h04,
    ELDET_REG_FALL_SEL = 6'h08,
    ELDET_REG_SOFT_TRIG = 6'h10,
    ELDET_REG_PENDING = 6'h20
  } eldet_reg_type;
endpackage

// ### core/eldet_external_line_unit.sv
// external line edge detector: 22 edge detectors with apb register file
`timescale 1ns/100ps
`include "eldet_consts.svh"

module eldet_external_line_unit #(
  parameter int unsigned NUM_LINES = `ELDET_NUM_LINES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] gpio_line_in,
  input wire logic low_voltage_detect,
  input wire logic clock_alarm,
  input wire logic usb_wakeup,
  input wire logic enet_wakeup,
  input wire logic i2c_wakeup,
  input wire logic uart_wakeup,
  output logic [NUM_LINES-1:0] line_irq,
  output logic [NUM_LINES-1:0] line_event,
  output logic any_event,
  output logic wakeup_req
);
  import eldet_pkg::*;

  // widths the fixed source map cannot serve are refused here
  initial begin
    if (NUM_LINES != `ELDET_NUM_LINES) begin
      $error("eldet: line count must match the fixed source map");
    end
    if (`ELDET_LINE_UART >= NUM_LINES) begin
      $error("eldet: internal source map exceeds the line count");
    end
    if (`ELDET_GPIO_LINES > `ELDET_LINE_LVD) begin
      $error("eldet: gpio lines overlap the internal sources");
    end
    if (NUM_LINES > $bits(pwdata)) begin
      $error("eldet: lines must fit one bus word");
    end
    if ($bits(`ELDET_OFF_PENDING) != `ELDET_ADDR_W) begin
      $error("eldet: offset width must match the decoded address width");
    end
  end

  localparam logic [NUM_LINES-1:0] ZERO_LINES = NUM_LINES'(`ELDET_RESET_WORD);
  localparam logic [31:0] ZERO_WORD = `ELDET_RESET_WORD;

  // line sources: gpio pins at the bottom, internal wakeups above
  logic [NUM_LINES-1:0] line_src;

  always_comb begin
    line_src = ZERO_LINES;
    line_src[`ELDET_GPIO_LINES-1:0] = gpio_line_in;
    line_src[`ELDET_LINE_LVD] = low_voltage_detect;
    line_src[`ELDET_LINE_ALARM] = clock_alarm;
    line_src[`ELDET_LINE_USB] = usb_wakeup;
    line_src[`ELDET_LINE_ENET] = enet_wakeup;
    line_src[`ELDET_LINE_I2C] = i2c_wakeup;
    line_src[`ELDET_LINE_UART] = uart_wakeup;
  end

  // bus decode: only aligned words inside the map are hits
  logic [`ELDET_ADDR_W-1:0] off;
  logic upper_zero;
  logic aligned;
  logic in_range;
  logic hit;
  logic wr_acc;
  logic rd_acc;
  eldet_reg_type sel;

  assign off = paddr[`ELDET_ADDR_W-1:0];
  assign upper_zero = (paddr[31:`ELDET_ADDR_W] == '0);
  assign aligned = (off[1:0] == 2'h0);
  assign in_range = (off <= `ELDET_OFF_PENDING);
  assign hit = upper_zero & aligned & in_range;
  // writes land in the access cycle; reads are fetched in the setup cycle
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;

  always_comb begin
    unique case (off)
      `ELDET_OFF_INT_MASK: sel = ELDET_REG_INT_MASK;
      `ELDET_OFF_EVT_MASK: sel = ELDET_REG_EVT_MASK;
      `ELDET_OFF_RISE_SEL: sel = ELDET_REG_RISE_SEL;
      `ELDET_OFF_FALL_SEL: sel = ELDET_REG_FALL_SEL;
      `ELDET_OFF_SOFT_TRIG: sel = ELDET_REG_SOFT_TRIG;
      default: sel = ELDET_REG_PENDING;
    endcase
  end

  // one write strobe per register
  logic wr_int_mask;
  logic wr_evt_mask;
  logic wr_rise_sel;
  logic wr_fall_sel;
  logic wr_soft_trig;
  logic wr_pending;
  logic [NUM_LINES-1:0] wdata_lines;

  assign wr_int_mask = wr_acc & hit & (sel == ELDET_REG_INT_MASK);
  assign wr_evt_mask = wr_acc & hit & (sel == ELDET_REG_EVT_MASK);
  assign wr_rise_sel = wr_acc & hit & (sel == ELDET_REG_RISE_SEL);
  assign wr_fall_sel = wr_acc & hit & (sel == ELDET_REG_FALL_SEL);
  assign wr_soft_trig = wr_acc & hit & (sel == ELDET_REG_SOFT_TRIG);
  assign wr_pending = wr_acc & hit & (sel == ELDET_REG_PENDING);
  assign wdata_lines = pwdata[NUM_LINES-1:0];

  // input sampler: the compare stage sees the last two samples of each line
  logic [NUM_LINES-1:0] sample_r;
  logic [NUM_LINES-1:0] sample_nxt;
  logic [NUM_LINES-1:0] prev_r;
  logic [NUM_LINES-1:0] prev_nxt;
  logic primed_r;
  logic primed_nxt;

  always_comb begin
    sample_nxt = line_src;
    // the first sample after reset seeds both stages, so no false edge follows
    prev_nxt = primed_r ? sample_r : line_src;
    primed_nxt = 1'b1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sample_r <= ZERO_LINES;
      prev_r <= ZERO_LINES;
      primed_r <= 1'b0;
    end else begin
      sample_r <= sample_nxt;
      prev_r <= prev_nxt;
      primed_r <= primed_nxt;
    end
  end

  // interrupt mask register
  logic [NUM_LINES-1:0] int_mask_r;
  logic [NUM_LINES-1:0] int_mask_nxt;

  always_comb begin
    int_mask_nxt = int_mask_r;
    if (wr_int_mask) begin
      int_mask_nxt = wdata_lines;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_mask_r <= ZERO_LINES;
    end else begin
      int_mask_r <= int_mask_nxt;
    end
  end

  // event mask register
  logic [NUM_LINES-1:0] evt_mask_r;
  logic [NUM_LINES-1:0] evt_mask_nxt;

  always_comb begin
    evt_mask_nxt = evt_mask_r;
    if (wr_evt_mask) begin
      evt_mask_nxt = wdata_lines;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      evt_mask_r <= ZERO_LINES;
    end else begin
      evt_mask_r <= evt_mask_nxt;
    end
  end

  // rising edge select register
  logic [NUM_LINES-1:0] rise_sel_r;
  logic [NUM_LINES-1:0] rise_sel_nxt;

  always_comb begin
    rise_sel_nxt = rise_sel_r;
    if (wr_rise_sel) begin
      rise_sel_nxt = wdata_lines;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rise_sel_r <= ZERO_LINES;
    end else begin
      rise_sel_r <= rise_sel_nxt;
    end
  end

  // falling edge select register
  logic [NUM_LINES-1:0] fall_sel_r;
  logic [NUM_LINES-1:0] fall_sel_nxt;

  always_comb begin
    fall_sel_nxt = fall_sel_r;
    if (wr_fall_sel) begin
      fall_sel_nxt = wdata_lines;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fall_sel_r <= ZERO_LINES;
    end else begin
      fall_sel_r <= fall_sel_nxt;
    end
  end

  // edge, trigger and flag logic, one lane per line
  logic [NUM_LINES-1:0] rise_edge;
  logic [NUM_LINES-1:0] fall_edge;
  logic [NUM_LINES-1:0] hw_trig;
  logic [NUM_LINES-1:0] sw_set;
  logic [NUM_LINES-1:0] trig;
  logic [NUM_LINES-1:0] clr;
  logic [NUM_LINES-1:0] soft_trig_r;
  logic [NUM_LINES-1:0] pending_r;
  logic [NUM_LINES-1:0] event_r;

  genvar g;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_line
      logic soft_bit_r;
      logic soft_bit_nxt;
      logic pend_bit_r;
      logic pend_bit_nxt;
      logic evt_bit_r;
      logic evt_bit_nxt;

      assign rise_edge[g] = sample_r[g] & ~prev_r[g];
      assign fall_edge[g] = ~sample_r[g] & prev_r[g];
      // both selects set give either direction
      assign hw_trig[g] = primed_r & ((rise_sel_r[g] & rise_edge[g])
                          | (fall_sel_r[g] & fall_edge[g]));
      // a bit already set does not fire again until its pending flag is cleared or a 0 is written to it
      assign sw_set[g] = wr_soft_trig & wdata_lines[g] & ~soft_bit_r;
      assign trig[g] = hw_trig[g] | sw_set[g];
      assign clr[g] = wr_pending & wdata_lines[g];

      always_comb begin
        soft_bit_nxt = soft_bit_r;
        if (wr_soft_trig) begin
          soft_bit_nxt = wdata_lines[g];
        end
        // the bit falls back once its pending flag is cleared
        if (clr[g]) begin
          soft_bit_nxt = 1'b0;
        end
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          soft_bit_r <= 1'b0;
        end else begin
          soft_bit_r <= soft_bit_nxt;
        end
      end

      always_comb begin
        pend_bit_nxt = pend_bit_r;
        if (clr[g]) begin
          pend_bit_nxt = 1'b0;
        end
        // a set in the same cycle as a clear wins
        if (trig[g] && int_mask_r[g]) begin
          pend_bit_nxt = 1'b1;
        end
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          pend_bit_r <= 1'b0;
        end else begin
          pend_bit_r <= pend_bit_nxt;
        end
      end

      always_comb begin
        evt_bit_nxt = trig[g] & evt_mask_r[g];
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          evt_bit_r <= 1'b0;
        end else begin
          evt_bit_r <= evt_bit_nxt;
        end
      end

      assign soft_trig_r[g] = soft_bit_r;
      assign pending_r[g] = pend_bit_r;
      assign event_r[g] = evt_bit_r;
    end
  endgenerate

  // read data: loaded in the setup cycle, held through the access cycle
  logic [NUM_LINES-1:0] rd_lines;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  always_comb begin
    rd_lines = ZERO_LINES;
    unique case (sel)
      ELDET_REG_INT_MASK: rd_lines = int_mask_r;
      ELDET_REG_EVT_MASK: rd_lines = evt_mask_r;
      ELDET_REG_RISE_SEL: rd_lines = rise_sel_r;
      ELDET_REG_FALL_SEL: rd_lines = fall_sel_r;
      ELDET_REG_SOFT_TRIG: rd_lines = soft_trig_r;
      ELDET_REG_PENDING: rd_lines = pending_r;
    endcase
  end

  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_acc) begin
      prdata_nxt = ZERO_WORD;
      if (hit) begin
        prdata_nxt[NUM_LINES-1:0] = rd_lines;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= ZERO_WORD;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // outputs: ready never stalls, so every access phase lasts one cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_r;
  assign line_irq = pending_r & int_mask_r;
  assign line_event = event_r;
  assign any_event = |event_r;
  assign wakeup_req = (|line_irq) | (|event_r);

endmodule // eldet_external_line_unit

// ### test/eldet_checker_sva.sv
// port-level checks for the external line edge detector
`timescale 1ns/100ps
module eldet_checker #(
  parameter int unsigned NUM_LINES = 22
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] gpio_line_in,
  input wire logic low_voltage_detect,
  input wire logic clock_alarm,
  input wire logic usb_wakeup,
  input wire logic enet_wakeup,
  input wire logic i2c_wakeup,
  input wire logic uart_wakeup,
  input wire logic [NUM_LINES-1:0] line_irq,
  input wire logic [NUM_LINES-1:0] line_event,
  input wire logic any_event,
  input wire logic wakeup_req
);
  logic [21:0] src;
  logic wr, bad;
  assign src = {uart_wakeup, i2c_wakeup, enet_wakeup, usb_wakeup, clock_alarm, low_voltage_detect, gpio_line_in};
  assign wr = psel && penable && pwrite;
  assign bad = paddr > 32'h14 || paddr[1:0] != 2'h0;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence s_xfer;
    psel && !penable ##1 psel && penable;
  endsequence
  evt_or_a: assert property (any_event == |line_event) else $error("any_event mismatch");
  wake_or_a: assert property (wakeup_req == (|line_irq || |line_event)) else $error("wakeup mismatch");
  bad_addr_a: assert property (s_xfer ##0 bad |-> pslverr && pready) else $error("no slave error");
  good_addr_a: assert property (s_xfer ##0 !bad |-> !pslverr && pready) else $error("stray error");
  resv_read_a: assert property (s_xfer ##0 !pwrite |-> prdata[31:22] == 10'h000) else $error("upper set");
  mask_off_a: assert property (wr && paddr == 32'h0 && pwdata == 32'h0 |=> line_irq == '0)
    else $error("irq not masked");
  irq_hold_a: assert property (!(wr && (paddr == 32'h0 || paddr == 32'h14)) |=>
    (line_irq & $past(line_irq)) == $past(line_irq)) else $error("irq dropped");
  irq_cause_a: assert property ((line_irq & ~$past(line_irq)) != '0 |->
    $past(wr && paddr <= 32'h10) || $past(src) != $past(src, 4)) else $error("irq without cause");
  event_cause_a: assert property (line_event != '0 |->
    $past(wr && paddr == 32'h10) || $past(src) != $past(src, 4)) else $error("event without cause");
endmodule // eldet_checker

// ### test/eldet_cpu_model.sv
// processor-side model: counts event pulses
`timescale 1ns/100ps
module eldet_cpu_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic any_event,
  output logic [7:0] ev_cnt_r
);
  logic [7:0] ev_cnt_nxt;
  // each pulse wakes a wait-for-event once
  always_comb begin
    ev_cnt_nxt = any_event ? ev_cnt_r + 8'h01 : ev_cnt_r;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ev_cnt_r <= 8'h00;
    else ev_cnt_r <= ev_cnt_nxt;
  end
endmodule // eldet_cpu_model

// ### test/eldet_external_line_unit_bench.sv
// testbench for the external line edge detector
`timescale 1ns/100ps
`include "eldet_consts.svh"
bind eldet_external_line_unit eldet_checker #(.NUM_LINES(NUM_LINES)) chk (.clock, .rstn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .gpio_line_in, .low_voltage_detect, .clock_alarm, .usb_wakeup,
  .enet_wakeup, .i2c_wakeup, .uart_wakeup, .line_irq, .line_event, .any_event, .wakeup_req);
module eldet_external_line_unit_bench;
  localparam logic [4:0] off_im = `ELDET_OFF_INT_MASK;
  localparam logic [4:0] off_pd = `ELDET_OFF_PENDING;
  logic clock = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, any_event, err;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [21:0] src = 22'h0, line_irq, line_event;
  logic [7:0] ev_cnt;
  logic wakeup_req;
  int n_mismatch = 0, checks_done = 0;
  eldet_external_line_unit dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
    .pready, .pslverr, .gpio_line_in(src[15:0]), .low_voltage_detect(src[16]), .clock_alarm(src[17]),
    .usb_wakeup(src[18]), .enet_wakeup(src[19]), .i2c_wakeup(src[20]), .uart_wakeup(src[21]), .line_irq,
    .line_event, .any_event, .wakeup_req);
  eldet_cpu_model cpu (.clock, .rstn, .any_event, .ev_cnt_r(ev_cnt));
  initial forever #20 clock = ~clock;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {27'h0, a};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k >= 50) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 6; i++) rd_chk(5'(4 * i), 32'h0);
    apb(1'h1, off_im, 32'h003f_ffff);
    rd_chk(off_im, 32'h003f_ffff);
    apb(1'h1, `ELDET_OFF_FALL_SEL, 32'h0015_5555);
    rd_chk(`ELDET_OFF_FALL_SEL, 32'h0015_5555);
    rd_chk(5'h18, 32'h0);
    chk(32'(err), 32'h1);
    $display("registers test done");
  endtask
  task automatic t_edges();
    logic [7:0] e0;
    apb(1'h1, off_im, 32'h0020_0007);
    apb(1'h1, `ELDET_OFF_EVT_MASK, 32'h0001_0000);
    apb(1'h1, `ELDET_OFF_RISE_SEL, 32'h0031_0005);
    apb(1'h1, `ELDET_OFF_FALL_SEL, 32'h0000_0006);
    e0 = ev_cnt;
    src <= 22'h31_0007; // sources are plain input levels
    repeat (2) @(posedge clock);
    rd_chk(off_pd, 32'h0020_0005);
    chk(32'(ev_cnt - e0), 32'h1);
    src <= 22'h0;
    repeat (2) @(posedge clock);
    rd_chk(off_pd, 32'h0020_0007);
    chk(32'(line_irq), 32'h0020_0007);
    chk(32'(wakeup_req), 32'h1);
    chk(32'(ev_cnt - e0), 32'h1);
    apb(1'h1, off_pd, 32'h0020_0005);
    rd_chk(off_pd, 32'h2);
    apb(1'h1, off_im, 32'h0);
    @(negedge clock);
    chk(32'(line_irq), 32'h0);
    chk(32'(wakeup_req), 32'h0);
    apb(1'h1, off_pd, 32'h2);
    $display("edges test done");
  endtask
  task automatic t_soft();
    logic [7:0] e0;
    apb(1'h1, off_im, 32'h0020_0000);
    apb(1'h1, `ELDET_OFF_EVT_MASK, 32'h0010_0000);
    e0 = ev_cnt;
    apb(1'h1, `ELDET_OFF_SOFT_TRIG, 32'h0030_0000);
    rd_chk(off_pd, 32'h0020_0000);
    chk(32'(ev_cnt - e0), 32'h1);
    apb(1'h1, off_pd, 32'h0020_0000);
    rd_chk(off_pd, 32'h0);
    $display("software trigger test done");
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'h1;
    t_regs();
    t_edges();
    t_soft();
    complete_run();
  end
endmodule // eldet_external_line_unit_bench
